// file: src/upcg_pkg.sv
package upcg_pkg;

    // Register map
    localparam logic [31:0] PCG_ADDR = 32'h5000_0e00;
    localparam logic [31:0] PCG_RESET = 32'h0000_0000;
    // Bits that software may write; all others read as zero or status
    localparam logic [31:0] PCG_WR_MASK = 32'hffff_e22f;

    // Control and status bit positions
    localparam int BIT_STOP_PCLK = 0;
    localparam int BIT_GATE_BUS = 1;
    localparam int BIT_CLAMP = 2;
    localparam int BIT_MOD_RST = 3;
    localparam int BIT_SLEEP_GATE = 5;
    localparam int BIT_SLEEPING = 6;
    localparam int BIT_DEEP_SLEEP = 7;
    localparam int BIT_WAKE_SRC = 9;
    localparam int BIT_RESTORED = 13;

    // Saved-state field and its sub-fields
    localparam int SAVE_LO = 14;
    localparam int SAVE_HI = 31;
    localparam int SAVE_W = 18;
    localparam int SV_DEV_MODE = 31;
    localparam int SV_PSPD_HI = 30;
    localparam int SV_PSPD_LO = 29;
    localparam int SV_ESPD_HI = 28;
    localparam int SV_ESPD_LO = 27;
    localparam int SV_ADDR_HI = 26;
    localparam int SV_ADDR_LO = 20;
    localparam int SV_TERM = 19;
    localparam int SV_XCVR_HI = 18;
    localparam int SV_XCVR_LO = 17;
    localparam int SV_PCLK_HI = 15;
    localparam int SV_PCLK_LO = 14;

    // Speed and transceiver encodings
    localparam logic [1:0] PORT_SPD_FULL = 2'h1;
    localparam logic [1:0] PORT_SPD_LOW = 2'h2;
    localparam logic [1:0] ENUM_SPD_LOW = 2'h2;
    localparam logic [1:0] ENUM_SPD_FULL = 2'h3;
    localparam logic [1:0] XCVR_FULL = 2'h1;
    localparam logic [1:0] XCVR_LOW = 2'h2;

    typedef enum logic [1:0] {
        RST_IDLE,
        RST_APPLY,
        RST_DONE
    } upcg_restore_t;

endpackage : upcg_pkg

// file: src/upcg_clk_gate.sv
`timescale 1ns/1ps
// Enable for a gated clock; it changes only while the gated logic is idle
module upcg_clk_gate (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic stopReq,
    input wire logic safePoint,
    output logic clkEnable
);
    import upcg_pkg::*;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            clkEnable <= 1'b1;
        end else if (safePoint) begin
            clkEnable <= !stopReq;
        end
    end

endmodule : upcg_clk_gate

// file: src/upcg_sleep_ctrl.sv
`timescale 1ns/1ps
// Sleep status of the transceiver and internal gating while sleeping
module upcg_sleep_ctrl (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic linkInL1,
    input wire logic l1SuspendAllowed,
    input wire logic sleepGatingEnable,
    output logic transceiverSleeping,
    output logic linkDeepSleepFlag,
    output logic transceiverL1SuspendLow,
    output logic sleepGateReq
);
    import upcg_pkg::*;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            transceiverSleeping <= 1'b0;
            linkDeepSleepFlag <= 1'b0;
            transceiverL1SuspendLow <= 1'b1;
        end else begin
            transceiverSleeping <= linkInL1;
            // Deep sleep only when the suspend line is really driven
            linkDeepSleepFlag <= linkInL1 && l1SuspendAllowed;
            transceiverL1SuspendLow <= !(linkInL1 && l1SuspendAllowed);
        end
    end

    // Fallback gating when the suspend line cannot be used
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sleepGateReq <= 1'b0;
        end else begin
            sleepGateReq <= linkInL1 && !l1SuspendAllowed && sleepGatingEnable;
        end
    end

endmodule : upcg_sleep_ctrl

// file: src/upcg_ctrl.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Software saves the saved-state field and writes it back on restore.
// RULE2 - Bit 31 device mode, 30:29 port speed, 28:27 enumerated speed.
// RULE3 - Bits 26:20 address, 19 termination, 18:17 transceiver, 15:14 clock.
// RULE4 - Writing one to bit 13 marks essential registers restored.
// RULE5 - Software sets wake source bit 9 before marking restore done.
// RULE6 - Read-only bit 7 shows transceiver deep sleep in L1.
// RULE7 - Read-only bit 6 shows transceiver sleeping.
// RULE8 - Bit 5 gates internal clocks in sleep without L1 suspend.
// RULE9 - Software sets module reset bit 3 at power off, clears later.
// RULE10 - Other core registers are accessible only while bit 3 is zero.
// RULE11 - Bit 2 clamps signals between powered and unpowered modules.
// RULE12 - Bit 1 gates the bus clock to the core modules.
// RULE13 - Bit 0 stops the transceiver clock.
// RULE14 - Clocks switch only at safe points; reserved bits read zero.
module upcg_ctrl (
    input wire logic mclk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Save point from the core
    input wire logic savePoint,
    input wire logic [upcg_pkg::SAVE_W-1:0] savedStateIn,
    // Idle indications used as clock-safe points
    input wire logic busIdle,
    input wire logic transceiverIdle,
    input wire logic coreIdle,
    // Link state from the transceiver side
    input wire logic linkInL1,
    input wire logic l1SuspendAllowed,
    // Outputs to the core and power switching
    output logic busClkEnable,
    output logic transceiverClkEnable,
    output logic coreClkEnable,
    output logic powerIsolationClamp,
    output logic powerdownModuleReset,
    output logic coreRegAccessEnable,
    output logic transceiverL1SuspendLow,
    output logic restoreStrobe,
    output logic wakeSourceSelect,
    output logic restoreDeviceMode,
    output logic [1:0] savedPortSpeed,
    output logic [1:0] savedEnumeratedSpeed,
    output logic [6:0] restoreDeviceAddr,
    output logic restoreFullSpeedTerm,
    output logic [1:0] restoreTransceiverSel,
    output logic [1:0] restorePortClkSel
);
    import upcg_pkg::*;

    logic [31:0] ctrlReg;
    logic [31:0] readValue;
    logic hit;
    logic wrAccess;
    logic sleepingFlag;
    logic deepSleepFlag;
    logic sleepGateReq;
    logic suspendLow;
    logic coreGateEnable;
    upcg_restore_t restoreState;
    upcg_restore_t next_restoreState;
    // Read-only status bits in the register view
    localparam logic [31:0] STATUS_BITS =
        (32'h1 << BIT_SLEEPING) | (32'h1 << BIT_DEEP_SLEEP);

    assign hit = (paddr == PCG_ADDR);
    assign wrAccess = psel && penable && pready && pwrite && hit;

    // Read view: writable bits as stored, status bits live
    always_comb begin
        readValue = ctrlReg & PCG_WR_MASK; // RULE14
        readValue[BIT_SLEEPING] = sleepingFlag; // RULE7
        readValue[BIT_DEEP_SLEEP] = deepSleepFlag; // RULE6
    end

    // APB answer: data ready in the first access cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            prdata <= (hit && !pwrite) ? readValue : 32'h0000_0000;
            pslverr <= !hit;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Control register; a save point overrides the saved-state field of a same-cycle write
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrlReg <= PCG_RESET;
        end else begin
            if (wrAccess) begin
                ctrlReg <= pwdata & PCG_WR_MASK; // RULE14
            end
            if (savePoint) begin
                ctrlReg[SAVE_HI:SAVE_LO] <= savedStateIn; // RULE1
            end
        end
    end

    // Restoration sequence started by the restoration-complete bit
    always_comb begin
        next_restoreState = restoreState;
        unique case (restoreState)
            RST_IDLE: begin
                if (ctrlReg[BIT_RESTORED]) begin
                    next_restoreState = RST_APPLY; // RULE4
                end
            end
            RST_APPLY: begin
                next_restoreState = RST_DONE;
            end
            RST_DONE: begin
                if (!ctrlReg[BIT_RESTORED]) begin
                    next_restoreState = RST_IDLE;
                end
            end
            default: begin
                next_restoreState = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            restoreState <= RST_IDLE;
        end else begin
            restoreState <= next_restoreState;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            restoreStrobe <= 1'b0;
        end else begin
            restoreStrobe <= (restoreState == RST_APPLY); // RULE4
        end
    end

    // Restored state handed to the core when restoration completes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wakeSourceSelect <= 1'b0;
            restoreDeviceMode <= 1'b0;
            savedPortSpeed <= 2'h0;
            savedEnumeratedSpeed <= 2'h0;
            restoreDeviceAddr <= 7'h00;
            restoreFullSpeedTerm <= 1'b0;
            restoreTransceiverSel <= 2'h0;
            restorePortClkSel <= 2'h0;
        end else if (restoreState == RST_APPLY) begin
            wakeSourceSelect <= ctrlReg[BIT_WAKE_SRC]; // RULE5
            restoreDeviceMode <= ctrlReg[SV_DEV_MODE]; // RULE2
            savedPortSpeed <= ctrlReg[SV_PSPD_HI:SV_PSPD_LO]; // RULE2
            savedEnumeratedSpeed <= ctrlReg[SV_ESPD_HI:SV_ESPD_LO]; // RULE2
            restoreDeviceAddr <= ctrlReg[SV_ADDR_HI:SV_ADDR_LO]; // RULE3
            restoreFullSpeedTerm <= ctrlReg[SV_TERM]; // RULE3
            restoreTransceiverSel <= ctrlReg[SV_XCVR_HI:SV_XCVR_LO]; // RULE3
            restorePortClkSel <= ctrlReg[SV_PCLK_HI:SV_PCLK_LO]; // RULE3
        end
    end

    // Power-down controls
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            powerIsolationClamp <= 1'b0;
            powerdownModuleReset <= 1'b0;
            coreRegAccessEnable <= 1'b1;
        end else begin
            powerIsolationClamp <= ctrlReg[BIT_CLAMP]; // RULE11
            powerdownModuleReset <= ctrlReg[BIT_MOD_RST]; // RULE9
            coreRegAccessEnable <= !ctrlReg[BIT_MOD_RST]; // RULE10
        end
    end

    // Bus clock to the core, stopped only while the bus is idle
    upcg_clk_gate u_bus_gate (
        .mclk(mclk),
        .resetn(resetn),
        .stopReq(ctrlReg[BIT_GATE_BUS]), // RULE12
        .safePoint(busIdle), // RULE14
        .clkEnable(busClkEnable)
    );

    // Transceiver clock
    upcg_clk_gate u_phy_gate (
        .mclk(mclk),
        .resetn(resetn),
        .stopReq(ctrlReg[BIT_STOP_PCLK]), // RULE13
        .safePoint(transceiverIdle), // RULE14
        .clkEnable(transceiverClkEnable)
    );

    // Internal clock gated in sleep when L1 suspend is unavailable
    upcg_clk_gate u_core_gate (
        .mclk(mclk),
        .resetn(resetn),
        .stopReq(sleepGateReq), // RULE8
        .safePoint(coreIdle), // RULE14
        .clkEnable(coreGateEnable)
    );

    upcg_sleep_ctrl u_sleep (
        .mclk(mclk),
        .resetn(resetn),
        .linkInL1(linkInL1),
        .l1SuspendAllowed(l1SuspendAllowed),
        .sleepGatingEnable(ctrlReg[BIT_SLEEP_GATE]), // RULE8
        .transceiverSleeping(sleepingFlag),
        .linkDeepSleepFlag(deepSleepFlag),
        .transceiverL1SuspendLow(suspendLow),
        .sleepGateReq(sleepGateReq)
    );

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            coreClkEnable <= 1'b1;
            transceiverL1SuspendLow <= 1'b1;
        end else begin
            coreClkEnable <= coreGateEnable;
            transceiverL1SuspendLow <= suspendLow;
        end
    end

    // Checks

    a_reserved_zero: assert property ( // RULE14
        @(posedge mclk) disable iff (!resetn)
        pready && psel && !pwrite && hit |->
            (prdata & ~(PCG_WR_MASK | STATUS_BITS)) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    a_sleep_flag: assert property ( // RULE7
        @(posedge mclk) disable iff (!resetn)
        linkInL1 |=> sleepingFlag)
        else $error("sleep flag not set one cycle after L1 entry");

    a_deep_sleep: assert property ( // RULE6
        @(posedge mclk) disable iff (!resetn)
        deepSleepFlag |-> $past(linkInL1) && $past(l1SuspendAllowed))
        else $error("deep sleep flag without cause");

    a_sleep_gating: assert property ( // RULE8
        @(posedge mclk) disable iff (!resetn)
        !ctrlReg[BIT_SLEEP_GATE] && $past(!ctrlReg[BIT_SLEEP_GATE])
            && coreIdle |=> coreGateEnable)
        else $error("core clock gated with sleep gating disabled");

    a_access_block: assert property ( // RULE10
        @(posedge mclk) disable iff (!resetn)
        $rose(ctrlReg[BIT_MOD_RST]) |=> !coreRegAccessEnable)
        else $error("core access still allowed after module reset");

    a_clamp_follow: assert property ( // RULE11
        @(posedge mclk) disable iff (!resetn)
        $changed(ctrlReg[BIT_CLAMP]) |=>
            powerIsolationClamp == $past(ctrlReg[BIT_CLAMP]))
        else $error("clamp output does not follow control bit");

    a_bus_gate_safe: assert property ( // RULE12
        @(posedge mclk) disable iff (!resetn)
        $changed(busClkEnable) |-> $past(busIdle)
            && busClkEnable == !$past(ctrlReg[BIT_GATE_BUS]))
        else $error("bus clock switched outside a safe point");

    a_phy_stop: assert property ( // RULE13
        @(posedge mclk) disable iff (!resetn)
        ctrlReg[BIT_STOP_PCLK] && transceiverIdle |=> !transceiverClkEnable)
        else $error("transceiver clock not stopped at idle");

    a_restore_pulse: assert property ( // RULE4
        @(posedge mclk) disable iff (!resetn)
        $rose(ctrlReg[BIT_RESTORED]) && restoreState == RST_IDLE
            |=> ##1 restoreStrobe ##1 !restoreStrobe)
        else $error("restore strobe missing or too long");

    a_wake_source: assert property ( // RULE5
        @(posedge mclk) disable iff (!resetn)
        restoreStrobe |-> wakeSourceSelect == $past(ctrlReg[BIT_WAKE_SRC]))
        else $error("wake source not taken at restore");

    a_saved_fields: assert property ( // RULE2
        @(posedge mclk) disable iff (!resetn)
        restoreStrobe |-> savedPortSpeed
            == $past(ctrlReg[SV_PSPD_HI:SV_PSPD_LO])
            && restoreDeviceAddr == $past(ctrlReg[SV_ADDR_HI:SV_ADDR_LO]))
        else $error("restored fields differ from saved state");

    a_save_wins: assert property ( // RULE1
        @(posedge mclk) disable iff (!resetn)
        savePoint |=> ctrlReg[SAVE_HI:SAVE_LO] == $past(savedStateIn))
        else $error("save point did not load saved state");

    a_modrst_out: assert property ( // RULE9
        @(posedge mclk) disable iff (!resetn)
        powerdownModuleReset == !coreRegAccessEnable)
        else $error("module reset and access enable disagree");

    a_write_mask: assert property ( // RULE14
        @(posedge mclk) disable iff (!resetn)
        wrAccess && !savePoint |=>
            ctrlReg == ($past(pwdata) & PCG_WR_MASK))
        else $error("write did not land through the writable mask");

    a_unmapped_ignored: assert property ( // RULE14
        @(posedge mclk) disable iff (!resetn)
        psel && penable && pready && !hit && !savePoint
            |=> $stable(ctrlReg))
        else $error("unmapped access changed the control register");

    a_bus_stop: assert property ( // RULE12
        @(posedge mclk) disable iff (!resetn)
        ctrlReg[BIT_GATE_BUS] && busIdle |=> !busClkEnable)
        else $error("bus clock not gated at idle");

    a_phy_resume: assert property ( // RULE13
        @(posedge mclk) disable iff (!resetn)
        !ctrlReg[BIT_STOP_PCLK] && transceiverIdle |=> transceiverClkEnable)
        else $error("transceiver clock not restarted at idle");

    a_core_sleep_gate: assert property ( // RULE8
        @(posedge mclk) disable iff (!resetn)
        sleepGateReq && coreIdle |=> !coreGateEnable)
        else $error("internal clock not gated in sleep");

    a_suspend_line: assert property ( // RULE6
        @(posedge mclk) disable iff (!resetn)
        transceiverL1SuspendLow == !$past(deepSleepFlag))
        else $error("suspend line disagrees with deep sleep flag");

    a_restore_link_fields: assert property ( // RULE3
        @(posedge mclk) disable iff (!resetn)
        restoreStrobe |-> restoreFullSpeedTerm == $past(ctrlReg[SV_TERM])
            && restoreTransceiverSel == $past(ctrlReg[SV_XCVR_HI:SV_XCVR_LO])
            && restorePortClkSel == $past(ctrlReg[SV_PCLK_HI:SV_PCLK_LO]))
        else $error("restored link fields differ from saved state");

endmodule : upcg_ctrl

// file: sim/upcg_xcvr_model.sv
`timescale 1ns/1ps
// Transceiver and power side: link state, idle points and save point
module upcg_xcvr_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic wantL1,
    input wire logic wantAllow,
    input wire logic wantIdle,
    input wire logic saveReq,
    input wire logic [17:0] saveVal,
    output logic busIdle,
    output logic transceiverIdle,
    output logic coreIdle,
    output logic linkInL1,
    output logic l1SuspendAllowed,
    output logic savePoint,
    output logic [17:0] savedStateIn
);
    logic [2:0] idleLag;
    initial begin
        {idleLag, busIdle, transceiverIdle, coreIdle} = '0;
        {linkInL1, l1SuspendAllowed, savePoint, savedStateIn} = '0;
    end
    // Idle points come up after a few cycles and drop at once
    always @(posedge mclk) begin
        idleLag <= resetn ? {idleLag[1:0], wantIdle} : 3'h0;
        busIdle <= idleLag[2] & wantIdle;
        transceiverIdle <= idleLag[1] & wantIdle;
        coreIdle <= idleLag[0] & wantIdle;
    end
    always @(posedge mclk) begin
        linkInL1 <= wantL1;
        l1SuspendAllowed <= wantAllow;
        savePoint <= saveReq;
        // State is only valid with the save pulse
        savedStateIn <= saveReq ? saveVal : ~savedStateIn;
    end
endmodule : upcg_xcvr_model

// file: sim/usb_power_clock_gating_test.sv
`timescale 1ns/1ps
module usb_power_clock_gating_test;
    import upcg_pkg::*;
    logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, shadow = 0, rnd = 32'h22;
    logic pready, pslverr, savePoint, busIdle, transceiverIdle, coreIdle;
    logic linkInL1, l1SuspendAllowed, busClkEnable, transceiverClkEnable;
    logic coreClkEnable, powerIsolationClamp, powerdownModuleReset;
    logic coreRegAccessEnable, transceiverL1SuspendLow, restoreStrobe;
    logic wakeSourceSelect, restoreDeviceMode, restoreFullSpeedTerm;
    logic [1:0] savedPortSpeed, savedEnumeratedSpeed;
    logic [1:0] restoreTransceiverSel, restorePortClkSel;
    logic [6:0] restoreDeviceAddr;
    logic [17:0] savedStateIn, saveVal = 0;
    logic wantL1 = 0, wantAllow = 0, wantIdle = 0, saveReq = 0;
    logic [32:0] expQ[$];
    logic [32:0] e;
    int err_total = 0, checks_done = 0;
    wire [7:0] obs = {busClkEnable, transceiverClkEnable, coreClkEnable,
        powerIsolationClamp, powerdownModuleReset, coreRegAccessEnable,
        transceiverL1SuspendLow, restoreStrobe};
    always #4 mclk = ~mclk;

    upcg_ctrl DUT (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .savePoint(savePoint), .savedStateIn(savedStateIn),
        .busIdle(busIdle), .transceiverIdle(transceiverIdle),
        .coreIdle(coreIdle), .linkInL1(linkInL1),
        .l1SuspendAllowed(l1SuspendAllowed), .busClkEnable(busClkEnable),
        .transceiverClkEnable(transceiverClkEnable),
        .coreClkEnable(coreClkEnable),
        .powerIsolationClamp(powerIsolationClamp),
        .powerdownModuleReset(powerdownModuleReset),
        .coreRegAccessEnable(coreRegAccessEnable),
        .transceiverL1SuspendLow(transceiverL1SuspendLow),
        .restoreStrobe(restoreStrobe), .wakeSourceSelect(wakeSourceSelect),
        .restoreDeviceMode(restoreDeviceMode),
        .savedPortSpeed(savedPortSpeed),
        .savedEnumeratedSpeed(savedEnumeratedSpeed),
        .restoreDeviceAddr(restoreDeviceAddr),
        .restoreFullSpeedTerm(restoreFullSpeedTerm),
        .restoreTransceiverSel(restoreTransceiverSel),
        .restorePortClkSel(restorePortClkSel));

    upcg_xcvr_model partner (.mclk(mclk), .resetn(resetn), .wantL1(wantL1),
        .wantAllow(wantAllow), .wantIdle(wantIdle), .saveReq(saveReq),
        .saveVal(saveVal), .busIdle(busIdle),
        .transceiverIdle(transceiverIdle), .coreIdle(coreIdle),
        .linkInL1(linkInL1), .l1SuspendAllowed(l1SuspendAllowed),
        .savePoint(savePoint), .savedStateIn(savedStateIn));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string name, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Completed transfers are compared against the oldest expectation
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = expQ.size() ? expQ.pop_front() : 33'h1_dead_beef;
            check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            check("prdata", prdata, e[31:0]);
        end
    end

    task automatic apb(input logic w, input logic [31:0] a, d,
            input logic [32:0] ex);
        int n;
        expQ.push_back(ex);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check("pready", 0, 1);
            finish_test();
        end
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [31:0] v);
        apb(1, PCG_ADDR, v, 33'h0);
        shadow = v & PCG_WR_MASK;
    endtask : wr

    task automatic rd;
        apb(0, PCG_ADDR, 0, {1'b0, shadow | {24'h0, wantL1 & wantAllow,
            wantL1, 6'h0}});
    endtask : rd

    task automatic waitObs(input logic [7:0] m, v);
        int n;
        n = 0;
        while ((obs & m) !== v && n < 12) begin
            @(posedge mclk);
            n++;
        end
        check("outputs", {24'h0, obs & m}, {24'h0, v});
        if (n >= 12) finish_test();
    endtask : waitObs

    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1;
        @(posedge mclk);
        waitObs(8'hff, 8'he6);
        rd();
        wr(32'hffff_dfff);
        rd();
        waitObs(8'h1c, 8'h18);
        apb(1, PCG_ADDR + 32'h4, 0, {1'b1, 32'h0});
        apb(0, PCG_ADDR + 32'h4, 0, {1'b1, 32'h0});
        rd();
        wr(32'h3);
        repeat (4) @(posedge mclk);
        waitObs(8'hdc, 8'hc4);
        wantIdle <= 1;
        waitObs(8'hc0, 8'h00);
        wr(32'h0);
        waitObs(8'hc0, 8'hc0);
        wantL1 <= 1;
        wantAllow <= 1;
        repeat (3) @(posedge mclk);
        rd();
        waitObs(8'h02, 8'h00);
        wantAllow <= 0;
        wr(32'h20);
        waitObs(8'h22, 8'h02);
        wr(32'h0);
        waitObs(8'h20, 8'h20);
        wantL1 <= 0;
        repeat (32) rnd = lfsr(rnd);
        saveVal <= rnd[31:14];
        saveReq <= 1;
        @(posedge mclk);
        saveReq <= 0;
        repeat (3) @(posedge mclk);
        shadow = {rnd[31:14], shadow[13:0]};
        rd();
        repeat (3) begin
            repeat (32) rnd = lfsr(rnd);
            wr(rnd & 32'hffff_dff0);
            wr((rnd & 32'hffff_dff0) | 32'h2000);
            waitObs(8'h01, 8'h01);
            check("restore", {17'h0, restoreDeviceMode, savedPortSpeed,
                savedEnumeratedSpeed, restoreDeviceAddr,
                restoreFullSpeedTerm, restoreTransceiverSel},
                {17'h0, rnd[31:17]});
            check("clk wake", {29'h0, restorePortClkSel, wakeSourceSelect},
                {29'h0, rnd[15:14], rnd[9]});
            @(posedge mclk);
            check("strobe", {31'h0, restoreStrobe}, 0);
        end
        finish_test();
    end
endmodule : usb_power_clock_gating_test
